// File: rtl/dwp_map.svh
// Constant map of the dual wiper serial register block
// Behaviour
// RULE_01 - Address 8 is access control; 0,1 wipers
// RULE_02 - Volatile select one: touch wipers only
// RULE_03 - Volatile select zero: reach initial values
// RULE_04 - Initial value reloads wiper at power-up
// RULE_05 - Initial value write also loads wiper
// RULE_06 - Initial value read leaves wiper unchanged
// RULE_07 - Host selects volatile before reading wiper
// RULE_08 - Host writes 40h before non-volatile write
// RULE_09 - Write frame: id, instruction, data byte
// RULE_10 - Read frame: id, instruction, data out
// RULE_11 - Id byte must be 0101 0000
// RULE_12 - Instruction 1011 read, 1100 write, address
// RULE_13 - Mode 0, MSB first, rise in
// RULE_14 - 20ms busy after select rises, blocks writes
// RULE_15 - Bad id or code ignores rest
`ifndef DWP_MAP_SVH
`define DWP_MAP_SVH
// ------------------------------------------------------------
// Addresses and codes
// ------------------------------------------------------------
`define DWP_ADDR_WIPER0    4'h0
`define DWP_ADDR_WIPER1    4'h1
`define DWP_ADDR_ACCESS    4'h8
`define DWP_ID_BYTE        8'h50
`define DWP_OP_READ        4'hB
`define DWP_OP_WRITE       4'hC
// ------------------------------------------------------------
// Access control fields and reset values
// ------------------------------------------------------------
`define DWP_ACR_VOL_BIT    7
`define DWP_ACR_PWR_BIT    6
`define DWP_ACR_BUSY_BIT   5
`define DWP_ACR_RESET      8'h40
`define DWP_WIPER_RESET    8'h40
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DWP_CLK_MHZ        100
`define DWP_NV_WRITE_MS    20
`define DWP_NV_WRITE_CYC   (`DWP_NV_WRITE_MS * 1000 * 1000 * `DWP_CLK_MHZ / 1000)
`endif

// File: rtl/dwp_pkg.sv
// Types shared by the dual wiper register block
package dwp_pkg;
    // Frame decoding states
    typedef enum logic [1:0] {DWP_ID, DWP_INSTR, DWP_DATA, DWP_IGNORE} dwp_frame_e;
    // Synchronised pin group
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic sdi;
    } dwp_pins_s;
endpackage : dwp_pkg

// File: rtl/dwp_nvmem.sv
// Two-word non-volatile store of initial wiper values
`timescale 1ns/100ps
`default_nettype none
`include "dwp_map.svh"
module dwp_nvmem
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // Write port
    input  wire logic       wr_i,
    input  wire logic       waddr_i,
    input  wire logic [7:0] wdata_i,
    // Registered read port
    input  wire logic       raddr_i,
    output logic      [7:0] rdata_o
);
    // Storage survives reset, as a non-volatile cell would
    logic [7:0] mem [0:1];

    initial
    begin
        mem[0] = `DWP_WIPER_RESET;
        mem[1] = `DWP_WIPER_RESET;
    end

    // Write port
    always_ff @(posedge mclk_i)
    begin
        if (wr_i)
            mem[waddr_i] <= wdata_i;
    end

    // Registered read
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rdata_o <= 8'h00;
        else
            rdata_o <= mem[raddr_i];
    end
endmodule : dwp_nvmem
`default_nettype wire

// File: rtl/dwp_top.sv
// Serial register access of a dual wiper potentiometer
`timescale 1ns/100ps
`default_nettype none
`include "dwp_map.svh"
module dwp_top
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // Serial pins
    input  wire logic       cs_n_i,
    input  wire logic       sck_i,
    input  wire logic       sdi_i,
    output logic            sdo_o,
    output logic            sdo_oe_o,
    // Wiper outputs and status
    output logic      [6:0] wiper0_o,
    output logic      [6:0] wiper1_o,
    output logic            power_down_control_o,
    output logic            nv_write_busy_flag_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    dwp_pkg::dwp_pins_s meta;            // First stage, read by stage two only
    dwp_pkg::dwp_pins_s pins;            // Second stage
    dwp_pkg::dwp_pins_s pins_d;          // Edge history

    // Two flops before any logic sees the pins
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            meta   <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
            pins   <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
            pins_d <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
        end
        else
        begin
            meta   <= '{cs_n: cs_n_i, sck: sck_i, sdi: sdi_i};
            pins   <= meta;
            pins_d <= pins;
        end
    end

    logic sck_rise;                      // Sample point
    logic sck_fall;                      // Shift-out point
    logic cs_fall;                       // Frame start
    logic cs_rise;                       // Frame end
    assign sck_rise = pins.sck & ~pins_d.sck & ~pins.cs_n;
    assign sck_fall = ~pins.sck & pins_d.sck & ~pins.cs_n;
    assign cs_fall  = ~pins.cs_n & pins_d.cs_n;
    assign cs_rise  = pins.cs_n & ~pins_d.cs_n;

    // ------------------------------------------------------------
    // Frame state and shifter
    // ------------------------------------------------------------
    dwp_pkg::dwp_frame_e state;          // Byte phase
    logic [2:0]          bitcnt;         // Bit within byte
    logic [6:0]          shreg;          // Bits gathered so far
    logic [7:0]          in_byte;        // Byte completing this edge
    logic                byte_done;      // Last bit sampled
    logic                op_write;       // Frame is a write
    logic [3:0]          addr;           // Register pointer
    assign in_byte   = {shreg, pins.sdi};
    assign byte_done = sck_rise & (bitcnt == 3'h7);

    // Valid id pattern check [RULE_11]
    function automatic logic id_ok(input logic [7:0] b);
        id_ok = (b == `DWP_ID_BYTE);
    endfunction : id_ok

    // Mode 0 MSB first sampling on rising edge [RULE_13]
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || cs_fall)
        begin
            bitcnt <= 3'h0;
            shreg  <= 7'h00;
        end
        else if (sck_rise)
        begin
            bitcnt <= bitcnt + 3'h1;
            shreg  <= in_byte[6:0];
        end
    end

    // Byte phase sequencing; bad id or code parks frame [RULE_15]
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || cs_fall)
        begin
            state    <= dwp_pkg::DWP_ID;
            op_write <= 1'b0;
            addr     <= 4'h0;
        end
        else if (byte_done)
        begin
            case (state)
                dwp_pkg::DWP_ID:
                    state <= id_ok(in_byte) ? dwp_pkg::DWP_INSTR : dwp_pkg::DWP_IGNORE;
                dwp_pkg::DWP_INSTR:
                begin
                    // Upper nibble code, lower nibble address [RULE_12]
                    op_write <= (in_byte[7:4] == `DWP_OP_WRITE);
                    addr     <= in_byte[3:0];
                    if (in_byte[7:4] == `DWP_OP_WRITE || in_byte[7:4] == `DWP_OP_READ)
                        state <= dwp_pkg::DWP_DATA;
                    else
                        state <= dwp_pkg::DWP_IGNORE;
                end
                dwp_pkg::DWP_DATA:
                    // Pointer advances per data byte, rolling past six
                    addr <= (addr == 4'h6) ? 4'h0 : addr + 4'h1;
                default:
                    state <= dwp_pkg::DWP_IGNORE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic       vol_sel;                 // Volatile select bit
    logic       pwr_bit;                 // Shutdown control, 1 = run
    logic [7:0] wiper0;                  // Volatile wiper 0
    logic [7:0] wiper1;                  // Volatile wiper 1
    logic       busy;                    // Non-volatile write in progress
    logic       nv_pend;                 // Write awaits select rising
    logic [31:0] busy_cnt;               // Programming timer
    logic       wr_strobe;               // Data byte write accepted
    logic       nv_wr;                   // Store initial value
    logic [7:0] nv_rdata;                // Stored value, registered
    logic       recall;                  // Power-up reload pending
    logic [7:0] acr_val;                 // Access control as read
    logic [1:0] recall_step;             // Recall progress
    logic       recall_idx;              // Word being recalled

    assign acr_val   = {vol_sel, pwr_bit, busy, 5'h00};
    // Write only when the frame is a valid write and not busy [RULE_09] [RULE_14]
    assign wr_strobe = byte_done & (state == dwp_pkg::DWP_DATA) & op_write & ~busy;
    // Initial value store only with volatile select clear [RULE_03]
    assign nv_wr     = wr_strobe & ~vol_sel & (addr[3:1] == 3'h0);

    dwp_nvmem u_nvmem
    (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .wr_i    (nv_wr),
        .waddr_i (addr[0]),
        .wdata_i (in_byte),
        .raddr_i (recall ? recall_idx : addr[0]),
        .rdata_o (nv_rdata)
    );

    // Power-up recall walks both words through the registered port [RULE_04]
    assign recall     = (recall_step != 2'h3);
    assign recall_idx = recall_step[0];

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            recall_step <= 2'h0;
        else if (recall)
            recall_step <= recall_step + 2'h1;
    end

    // Access control decode [RULE_01]
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            vol_sel <= 1'b0;
            pwr_bit <= 1'b1;
        end
        else if (wr_strobe && addr == `DWP_ADDR_ACCESS)
        begin
            vol_sel <= in_byte[`DWP_ACR_VOL_BIT];
            pwr_bit <= in_byte[`DWP_ACR_PWR_BIT];
        end
    end

    // Wipers: volatile write, mirrored initial value write, recall [RULE_02] [RULE_05]
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            wiper0 <= `DWP_WIPER_RESET;
            wiper1 <= `DWP_WIPER_RESET;
        end
        else if (recall && recall_step != 2'h0)
        begin
            if (recall_step == 2'h1)
                wiper0 <= nv_rdata;
            else
                wiper1 <= nv_rdata;
        end
        else if (wr_strobe && addr == `DWP_ADDR_WIPER0)
            wiper0 <= in_byte;
        else if (wr_strobe && addr == `DWP_ADDR_WIPER1)
            wiper1 <= in_byte;
    end

    // Busy starts at select rising after a stored write, lasts 20 ms [RULE_14]
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            nv_pend  <= 1'b0;
            busy     <= 1'b0;
            busy_cnt <= 32'h0;
        end
        else if (nv_pend && cs_rise)
        begin
            nv_pend  <= 1'b0;
            busy     <= 1'b1;
            busy_cnt <= 32'(`DWP_NV_WRITE_CYC - 1);
        end
        else
        begin
            if (nv_wr)
                nv_pend <= 1'b1;
            if (busy)
            begin
                busy_cnt <= busy_cnt - 32'h1;
                if (busy_cnt == 32'h0)
                    busy <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rd_word;                 // Addressed value
    logic [7:0] out_sh;                  // Output shifter
    logic       rd_active;               // Driving data

    // Initial value read leaves wiper untouched [RULE_06]
    always_comb
    begin
        rd_word = 8'h00;
        if (addr == `DWP_ADDR_ACCESS)
            rd_word = acr_val;
        else if (addr == `DWP_ADDR_WIPER0)
            rd_word = vol_sel ? wiper0 : nv_rdata;
        else if (addr == `DWP_ADDR_WIPER1)
            rd_word = vol_sel ? wiper1 : nv_rdata;
    end

    // Shift addressed byte out on falling edges [RULE_10] [RULE_13]
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || cs_fall || pins.cs_n)
        begin
            rd_active <= 1'b0;
            out_sh    <= 8'h00;
        end
        else if (sck_fall && bitcnt == 3'h0)
        begin
            rd_active <= (state == dwp_pkg::DWP_DATA) & ~op_write;
            out_sh    <= rd_word;
        end
        else if (sck_fall)
            out_sh <= {out_sh[6:0], 1'b0};
    end

    // Outputs from flops; open drain drives only low bits
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sdo_o                <= 1'b0;
            sdo_oe_o             <= 1'b0;
            wiper0_o             <= 7'h40;
            wiper1_o             <= 7'h40;
            power_down_control_o <= 1'b1;
            nv_write_busy_flag_o <= 1'b0;
        end
        else
        begin
            sdo_o                <= 1'b0;
            sdo_oe_o             <= rd_active & ~out_sh[7];
            wiper0_o             <= wiper0[6:0];
            wiper1_o             <= wiper1[6:0];
            power_down_control_o <= pwr_bit;
            nv_write_busy_flag_o <= busy;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_BAD_ID_BLOCKS: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_15]
        (byte_done && state == dwp_pkg::DWP_ID && !id_ok(in_byte)) |=> state == dwp_pkg::DWP_IGNORE)
        else $error("frame not parked after bad id");
    AST_VOL_NO_NV: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_02]
        vol_sel |-> !nv_wr)
        else $error("nv write with volatile select");
    AST_MIRROR: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_05]
        (nv_wr && addr == 4'h0 && !recall) |=> wiper0 == $past(in_byte))
        else $error("wiper not mirrored");
    AST_BUSY_BLOCK: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_14]
        (busy && byte_done && state == dwp_pkg::DWP_DATA && op_write)
            |=> $stable(wiper0) && $stable(wiper1) && $stable(vol_sel) && $stable(pwr_bit))
        else $error("write while busy");
    AST_BUSY_START: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_14]
        (nv_pend && cs_rise) |=> busy ##1 busy)
        else $error("busy not started");
    AST_ACR_WR: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_01]
        (wr_strobe && addr == 4'h8) |=> vol_sel == $past(in_byte[7]))
        else $error("access control not written");
    AST_NV_READ_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_06]
        (!wr_strobe && !recall) |=> $stable(wiper0) && $stable(wiper1))
        else $error("wiper changed without write");
    AST_READ_NO_WR: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE_10]
        (byte_done && state == dwp_pkg::DWP_DATA && !op_write)
            |=> $stable(wiper0) && $stable(wiper1) && $stable(vol_sel))
        else $error("read frame wrote");
endmodule : dwp_top
`default_nettype wire

// File: verification/dwp_host_model.sv
// Behavioural serial host that frames three-byte register accesses
`timescale 1ns/100ps
`default_nettype none
module dwp_host_model
(
    // Serial pins toward the device
    output var logic cs_n_o,
    output var logic sck_o,
    output var logic sdi_o,
    // Open-drain data from the device
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    // ------------------------------------------------------------
    // Wire level
    // ------------------------------------------------------------
    // Pull-up holds the line high unless the device pulls it
    wire logic sdo_line;
    assign sdo_line = sdo_oe_i ? sdo_i : 1'b1;

    // Idle pins: deselected, clock still
    initial
    begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        sdi_o  = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame task
    // ------------------------------------------------------------
    // Id, instruction and data byte in one select-low period
    task automatic frame(input logic [23:0] tx, output logic [7:0] rx);
        cs_n_o = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            // Data set while the clock is low, MSB first
            sdi_o = tx[i];
            #62.5;
            sck_o = 1'b1;
            // Third byte is taken from the line at the rising edge
            if (i < 8)
                rx[i] = sdo_line;
            #62.5;
            sck_o = 1'b0;
        end
        #62.5;
        cs_n_o = 1'b1;
        // A released line must not keep looking valid
        sdi_o = ~sdi_o;
        #250;
    endtask : frame
endmodule : dwp_host_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench of the dual wiper serial register block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       mclk = 1'b0; // 100 MHz
    logic       rst  = 1'b1; // Synchronous, active high
    logic       cs_n;
    logic       sck;
    logic       sdi;
    logic       sdo;
    logic       sdo_oe;
    logic [6:0] wiper0;
    logic [6:0] wiper1;
    logic       pwr;
    logic       busy;
    int         n_mismatch = 0;
    int         tests_run  = 0;
    logic [7:0] got;
    // Row: address, byte written, value expected back
    typedef struct packed {logic [3:0] addr; logic [7:0] data; logic [7:0] exp;} dwp_row_s;
    dwp_row_s   rows [4] = '{'{4'h0, 8'h00, 8'h00}, '{4'h1, 8'h7F, 8'h7F},
                            '{4'h0, 8'h2A, 8'h2A}, '{4'h1, 8'h55, 8'h55}};
    // Refused frames: bad ids, then bad instruction codes
    logic [23:0] bad [4] = '{24'h58B000, 24'h40C011, 24'h50D011, 24'h50A011};

    always #5 mclk = ~mclk;

    // ------------------------------------------------------------
    // Device and host
    // ------------------------------------------------------------
    dwp_top i_dut
    (
        .mclk_i               (mclk),
        .rst_i                (rst),
        .cs_n_i               (cs_n),
        .sck_i                (sck),
        .sdi_i                (sdi),
        .sdo_o                (sdo),
        .sdo_oe_o             (sdo_oe),
        .wiper0_o             (wiper0),
        .wiper1_o             (wiper1),
        .power_down_control_o (pwr),
        .nv_write_busy_flag_o (busy)
    );
    dwp_host_model i_host
    (
        .cs_n_o   (cs_n),
        .sck_o    (sck),
        .sdi_o    (sdi),
        .sdo_i    (sdo),
        .sdo_oe_i (sdo_oe)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Let synchronised updates land, sample just after an edge
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle

    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        logic [7:0] rx;
        i_host.frame({8'h50, 4'hC, addr, data}, rx);
        idle(5);
    endtask : wr

    task automatic rd(input logic [3:0] addr, output logic [7:0] data);
        i_host.frame({8'h50, 4'hB, addr, 8'h00}, data);
        idle(5);
    endtask : rd

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        idle(8);
        check("wiper0 at start", 8'h40, {1'b0, wiper0});
        check("wiper1 at start", 8'h40, {1'b0, wiper1});
        check("run bit at start", 8'h01, {7'h00, pwr});
        check("busy at start", 8'h00, {7'h00, busy});
        check("oe at start", 8'h00, {7'h00, sdo_oe});
        // Select volatile access before touching wipers
        wr(4'h8, 8'hC0);
        foreach (rows[k])
        begin
            wr(rows[k].addr, rows[k].data);
            got = rows[k].addr[0] ? {1'b0, wiper1} : {1'b0, wiper0};
            check("wiper out", rows[k].exp, got);
            rd(rows[k].addr, got);
            check("wiper read", rows[k].exp, got);
        end
        rd(4'h8, got);
        check("control read", 8'hC0, got);
        // Shutdown bit follows the control register
        wr(4'h8, 8'h80);
        check("run bit cleared", 8'h00, {7'h00, pwr});
        // Busy bit is read only
        wr(4'h8, 8'hE0);
        rd(4'h8, got);
        check("busy bit read only", 8'hC0, got);
        check("run bit set", 8'h01, {7'h00, pwr});
        // Refused frames neither write nor drive the line
        foreach (bad[k])
        begin
            i_host.frame(bad[k], got);
            idle(5);
            check("refused frame line", 8'hFF, got);
            check("refused frame wiper0", 8'h2A, {1'b0, wiper0});
        end
        // Stored values untouched by volatile traffic
        wr(4'h8, 8'h40);
        rd(4'h1, got);
        check("stored 1 read", 8'h40, got);
        check("wiper1 kept on read", 8'h55, {1'b0, wiper1});
        rd(4'h0, got);
        check("stored 0 read", 8'h40, got);
        check("wiper0 kept on read", 8'h2A, {1'b0, wiper0});
        // Stored write mirrors into the wiper and starts busy
        wr(4'h0, 8'h77);
        check("wiper0 mirror", 8'h77, {1'b0, wiper0});
        for (int n = 0; n < 20 && busy !== 1'b1; n++)
            idle(1);
        if (busy !== 1'b1)
        begin
            n_mismatch++;
            $display("[ERR] busy expected 1 seen %b", busy);
        end
        rd(4'h0, got);
        check("stored 0 new", 8'h77, got);
        rd(4'h8, got);
        check("control while busy", 8'h60, got);
        // Writes are refused while the store runs
        wr(4'h1, 8'h11);
        check("wiper1 while busy", 8'h55, {1'b0, wiper1});
        // A fresh start recalls stored positions
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        idle(8);
        check("wiper0 recalled", 8'h77, {1'b0, wiper0});
        check("wiper1 recalled", 8'h40, {1'b0, wiper1});
        check("busy after restart", 8'h00, {7'h00, busy});
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
